// ### hdl/byte_buffer.v
// two-entry byte buffer with valid/ready on both sides
`timescale 1ns/1ps
module byte_buffer (
  input  wire       clk_in,
  input  wire       rst_in,
  input  wire       in_valid_in,
  output wire       in_ready_out,
  input  wire [7:0] in_data_in,
  output wire       out_valid_out,
  input  wire       out_ready_in,
  output wire [7:0] out_data_out
);
  reg  [7:0] mem_r [0:1];
  reg        wp_r;
  reg        rp_r;
  reg  [1:0] cnt_r;
  wire       push;
  wire       pop;

  assign in_ready_out  = (cnt_r != 2'h2);
  assign out_valid_out = (cnt_r != 2'h0);
  assign out_data_out  = mem_r[rp_r];
  assign push = in_valid_in & in_ready_out;
  assign pop  = out_valid_out & out_ready_in;

  always @(posedge clk_in) begin
    if (rst_in) begin
      wp_r  <= 1'b0;
      rp_r  <= 1'b0;
      cnt_r <= 2'h0;
    end else begin
      if (push) begin
        mem_r[wp_r] <= in_data_in;
        wp_r        <= ~wp_r;
      end
      if (pop) begin
        rp_r <= ~rp_r;
      end
      cnt_r <= cnt_r + {1'b0, push} - {1'b0, pop};
    end
  end
endmodule

// ### hdl/serial_host_port.v
// serial host port: framing, shifting, byte memory, busy/done pin
`timescale 1ns/1ps
`include "serial_port_consts.vh"
module serial_host_port (
  input  wire clk_in,
  input  wire sys_rst_in,
  input  wire rst_n_in,
  input  wire cs_n_in,
  input  wire sck_in,
  input  wire sdi_in,
  output reg  sdo_out,
  output reg  sdo_oe_out,
  output reg  done_out
);
  localparam ST_INSTR = 3'h0;
  localparam ST_ADH   = 3'h1;
  localparam ST_ADL   = 3'h2;
  localparam ST_WDATA = 3'h3;
  localparam ST_RDATA = 3'h4;
  localparam ST_IGN   = 3'h5;

  localparam B_RESET = 2'h0;
  localparam B_START = 2'h1;
  localparam B_IDLE  = 2'h2;
  localparam B_CONV  = 2'h3;

  reg  [7:0]  mem_r [0:`MEM_DEPTH-1];
  reg  [2:0]  cs_sy_r, sck_sy_r, sdi_sy_r, rst_sy_r;
  reg         cs_d_r, sck_d_r;
  reg  [2:0]  st_r;
  reg  [2:0]  bit_r;
  reg  [7:0]  sh_r;
  reg  [15:0] addr_r;
  reg  [7:0]  tx_r;
  reg  [1:0]  bst_r;
  reg  [15:0] tmr_r;
  reg         conv_req_r;
  wire        cs_n, sck, sdi, rst_pin_n;
  wire        sck_rise, sck_fall, cs_fall, cs_rise;
  wire [7:0]  byte_nxt;
  wire        byte_done;
  wire        buf_ready, buf_valid;
  wire [7:0]  buf_data;
  wire        rd_pop;

  // double flops on every pin; third stage only for edge detection
  always @(posedge clk_in) begin
    cs_sy_r  <= {cs_sy_r[1:0], cs_n_in};
    sck_sy_r <= {sck_sy_r[1:0], sck_in};
    sdi_sy_r <= {sdi_sy_r[1:0], sdi_in};
    rst_sy_r <= {rst_sy_r[1:0], rst_n_in};
    cs_d_r   <= cs_sy_r[1];
    sck_d_r  <= sck_sy_r[1];
  end
  assign cs_n      = cs_sy_r[1];
  assign sck       = sck_sy_r[1];
  assign sdi       = sdi_sy_r[1];
  assign rst_pin_n = rst_sy_r[1];
  assign sck_rise  = sck & ~sck_d_r & ~cs_n;
  assign sck_fall  = ~sck & sck_d_r & ~cs_n;
  assign cs_fall   = ~cs_n & cs_d_r;
  assign cs_rise   = cs_n & ~cs_d_r;
  assign byte_nxt  = {sh_r[6:0], sdi};
  assign byte_done = sck_rise & (bit_r == 3'h7);

  function is_cmd;
    input [15:0] a;
    begin
      is_cmd = (a == `CMD_ADDR);
    end
  endfunction

  // read bytes pass the buffer so a slow shifter never drops a fetched byte
  wire rd_fetch = (st_r == ST_RDATA) & buf_ready & ~buf_valid & ~cs_n;
  assign rd_pop = (st_r == ST_RDATA) & sck_fall & (bit_r == 3'h0) & buf_valid;

  // flushed at every frame edge so a prefetched byte never leaks into the next read
  byte_buffer u_buf (
    .clk_in        (clk_in),
    .rst_in        (sys_rst_in | ~rst_pin_n | cs_fall | cs_rise),
    .in_valid_in   (rd_fetch),
    .in_ready_out  (buf_ready),
    .in_data_in    (mem_r[addr_r[`MEM_AW-1:0]]),
    .out_valid_out (buf_valid),
    .out_ready_in  (rd_pop),
    .out_data_out  (buf_data)
  );

  always @(posedge clk_in) begin
    if (sys_rst_in | ~rst_pin_n) begin
      st_r       <= ST_INSTR;
      bit_r      <= 3'h0;
      sh_r       <= 8'h00;
      addr_r     <= 16'h0000;
      tx_r       <= 8'h00;
      sdo_out    <= 1'b0;
      sdo_oe_out <= 1'b0;
      conv_req_r <= 1'b0;
    end else begin
      conv_req_r <= 1'b0;
      if (cs_fall | cs_rise) begin
        st_r       <= ST_INSTR;
        bit_r      <= 3'h0;
        sdo_oe_out <= 1'b0;
      end else if (cs_n) begin
        sdo_oe_out <= 1'b0;
      end else begin
        if (sck_rise) begin
          sh_r  <= byte_nxt;
          bit_r <= bit_r + 3'h1;
        end
        if (rd_fetch) begin
          addr_r <= addr_r + 16'h0001;
        end
        if (byte_done) begin
          case (st_r)
            ST_INSTR: begin
              if (byte_nxt == `INSTR_READ || byte_nxt == `INSTR_WRITE) begin
                st_r <= ST_ADH;
                tx_r <= byte_nxt;
              end else begin
                st_r <= ST_IGN;
              end
            end
            ST_ADH: begin
              addr_r[15:8] <= byte_nxt;
              st_r         <= ST_ADL;
            end
            ST_ADL: begin
              addr_r[7:0] <= byte_nxt;
              st_r        <= (tx_r == `INSTR_READ) ? ST_RDATA : ST_WDATA;
            end
            ST_WDATA: begin
              mem_r[addr_r[`MEM_AW-1:0]] <= byte_nxt;
              if (is_cmd(addr_r) && byte_nxt[`CMD_START_BIT]) begin
                conv_req_r <= 1'b1;
              end
              addr_r <= addr_r + 16'h0001;
            end
            ST_RDATA: st_r <= ST_RDATA;
            default: st_r <= ST_IGN;
          endcase
        end
        if (rd_pop) begin
          sdo_oe_out <= 1'b1;
          sdo_out    <= buf_data[7];
          tx_r       <= {buf_data[6:0], 1'b0};
        end else if (st_r == ST_RDATA && sck_fall && sdo_oe_out) begin
          sdo_out <= tx_r[7];
          tx_r    <= {tx_r[6:0], 1'b0};
        end
      end
    end
  end

  // busy sequencer: start-up after reset release, then conversions
  always @(posedge clk_in) begin
    if (sys_rst_in | ~rst_pin_n) begin
      bst_r    <= B_RESET;
      tmr_r    <= 16'h0000;
      done_out <= 1'b0;
    end else begin
      case (bst_r)
        B_RESET: begin
          bst_r    <= B_START;
          tmr_r    <= `STARTUP_CYCLES;
          done_out <= 1'b0;
        end
        B_START, B_CONV: begin
          done_out <= 1'b0;
          if (tmr_r == 16'h0001) begin
            bst_r    <= B_IDLE;
            done_out <= 1'b1;
          end
          tmr_r <= tmr_r - 16'h0001;
        end
        B_IDLE: begin
          done_out <= 1'b1;
          if (conv_req_r) begin
            bst_r    <= B_CONV;
            tmr_r    <= `CONV_CYCLES;
            done_out <= 1'b0;
          end
        end
        default: bst_r <= B_RESET;
      endcase
    end
  end
endmodule

// ### hdl/serial_port_consts.vh
// constants for the serial host port of the temperature measurement device
`ifndef SERIAL_PORT_CONSTS_VH
`define SERIAL_PORT_CONSTS_VH
`define INSTR_READ      8'h03
`define INSTR_WRITE     8'h02
`define CMD_ADDR        16'h0000
`define CMD_START_BIT   7
`define CMD_DONE_BIT    6
`define CMD_RESET_VAL   8'h40
`define MEM_DEPTH       1024
`define MEM_AW          10
`define STARTUP_CYCLES  16'h0400
`define CONV_CYCLES     16'h0800
`endif

// ### tb/serial_host_port_chk.sv
// checker on the serial port pins
`timescale 1ns/1ps
module serial_host_port_chk (
  input wire logic clk_in,
  input wire logic sys_rst_in,
  input wire logic rst_n_in,
  input wire logic cs_n_in,
  input wire logic sck_in,
  input wire logic sdo_out,
  input wire logic sdo_oe_out,
  input wire logic done_out
);
  default clocking
    @(posedge clk_in);
  endclocking
  default disable iff (sys_rst_in);
  sequence s_idle;
    cs_n_in [*6];
  endsequence
  sequence s_high;
    (sdo_oe_out && sck_in) [*3];
  endsequence
  property p_oe_idle; s_idle |-> !sdo_oe_out; endproperty
  a_oe_idle: assert property (p_oe_idle) else $error("oe idle");
  property p_oe_end; $rose(cs_n_in) |-> ##[1:6] !sdo_oe_out; endproperty
  a_oe_end: assert property (p_oe_end) else $error("oe end");
  property p_oe_sel; $rose(sdo_oe_out) |-> !$past(cs_n_in, 2); endproperty
  a_oe_sel: assert property (p_oe_sel) else $error("oe sel");
  // sdo may only move in the low phase of the serial clock
  property p_sdo_fall; s_high |-> $stable(sdo_out); endproperty
  a_sdo_fall: assert property (p_sdo_fall) else $error("sdo edge");
  property p_rst_hold; !rst_n_in [*6] |-> !done_out; endproperty
  a_rst_hold: assert property (p_rst_hold) else $error("rst hold");
  property p_startup; $rose(rst_n_in) |-> !done_out [*8]; endproperty
  a_startup: assert property (p_startup) else $error("startup");
  property p_conv; $fell(done_out) && rst_n_in |-> !done_out [*8]; endproperty
  a_conv: assert property (p_conv) else $error("conv");
  property p_quiet; (cs_n_in && rst_n_in) [*8] |-> !$fell(done_out); endproperty
  a_quiet: assert property (p_quiet) else $error("quiet");
endmodule
bind serial_host_port serial_host_port_chk u_chk (
  .clk_in, .sys_rst_in, .rst_n_in, .cs_n_in, .sck_in, .sdo_out, .sdo_oe_out, .done_out
);

// ### tb/spi_host_model.sv
// host side model: frames, shifts and samples the serial line
`timescale 1ns/1ps
module spi_host_model (
  input  wire clk_in,
  input  wire sdo_in,
  input  wire oe_in,
  output reg  cs_n_out = 1'b1,
  output reg  sck_out = 1'b0,
  output reg  sdi_out = 1'b0
);
  reg line_r = 1'b0;
  // a released line toggles so a stale bit never reads as valid
  always @(posedge clk_in) line_r <= oe_in ? sdo_in : ~line_r;
  task sel(input v);
    begin
      repeat (4) @(posedge clk_in);
      cs_n_out <= v;
      repeat (4) @(posedge clk_in);
    end
  endtask
  task xfer(input [7:0] tx, output [7:0] rx);
    integer i;
    begin
      for (i = 7; i >= 0; i = i - 1) begin
        sdi_out <= tx[i];
        repeat (4) @(posedge clk_in);
        sck_out <= 1'b1;
        repeat (4) @(posedge clk_in);
        rx[i] = line_r;
        sck_out <= 1'b0;
      end
    end
  endtask
endmodule

// ### tb/test_serial_host_port.sv
// self-checking bench for the serial host port
`timescale 1ns/1ps
`include "serial_port_consts.vh"
`define CHK(n, e, g) begin comparisons = comparisons + 1; if ((g) !== (e)) begin \
  n_errors = n_errors + 1; $display("ERROR %s exp %h got %h", n, e, g); end end
module test_serial_host_port;
  reg          clk_in;
  reg          sys_rst_in = 1'b1;
  reg          rst_n_in = 1'b1;
  wire         cs_n_in, sck_in, sdi_in, sdo_out, sdo_oe_out, done_out;
  integer      n_errors = 0;
  integer      comparisons = 0;
  integer      ticks = 0;
  integer      cyc;
  integer      i;
  reg   [7:0]  q;
  reg   [23:0] rows [0:3];
  serial_host_port u_dut (.clk_in, .sys_rst_in, .rst_n_in, .cs_n_in, .sck_in, .sdi_in,
    .sdo_out, .sdo_oe_out, .done_out);
  spi_host_model u_host (.clk_in(clk_in), .sdo_in(sdo_out), .oe_in(sdo_oe_out),
    .cs_n_out(cs_n_in), .sck_out(sck_in), .sdi_out(sdi_in));
  initial begin
    clk_in = 1'b0;
    forever #25 clk_in = ~clk_in;
  end
  always @(posedge clk_in) begin
    ticks = ticks + 1;
    if (ticks == 20000) begin
      n_errors = n_errors + 1;
      stop_test;
    end
  end
  task frame(input [7:0] ins, input [15:0] a, input [7:0] d);
    begin
      u_host.sel(1'b0);
      u_host.xfer(ins, q);
      u_host.xfer(a[15:8], q);
      u_host.xfer(a[7:0], q);
      u_host.xfer(d, q);
      u_host.sel(1'b1);
    end
  endtask
  task wait_done;
    begin
      cyc = 0;
      while (done_out !== 1'b1 && cyc < 3000) begin
        @(posedge clk_in);
        cyc = cyc + 1;
      end
    end
  endtask
  task stop_test;
    begin
      $display("comparisons %0d errors %0d", comparisons, n_errors);
      if (n_errors == 0 && comparisons > 0)
        $display("Testbench passed");
      else
        $display("Testbench failed");
      $finish;
    end
  endtask
  initial begin
    rows[0] = {16'h0001, 8'hA5};
    rows[1] = {16'h03FF, 8'h5A};
    rows[2] = {16'h0200, 8'h80};
    rows[3] = {16'h0155, 8'h01};
    repeat (12) @(posedge clk_in);
    sys_rst_in <= 1'b0;
    @(posedge clk_in);
    #1 `CHK("boot busy", 1'b0, done_out)
    wait_done;
    `CHK("boot time", 1'b1, cyc > `STARTUP_CYCLES - 4 && cyc < `STARTUP_CYCLES + 16)
    $display("boot finished");
    for (i = 0; i < 4; i = i + 1) begin
      frame(`INSTR_WRITE, rows[i][23:8], rows[i][7:0]);
    end
    // bit7 set away from the command byte must not start a conversion
    `CHK("no conv", 1'b1, done_out)
    for (i = 0; i < 4; i = i + 1) begin
      frame(`INSTR_READ, rows[i][23:8], 8'h00);
      `CHK("read", rows[i][7:0], q)
    end
    $display("rows finished");
    u_host.xfer(`INSTR_WRITE, q);
    u_host.xfer(8'h00, q);
    u_host.xfer(8'h01, q);
    u_host.xfer(8'hFF, q);
    `CHK("idle oe", 1'b0, sdo_oe_out)
    frame(`INSTR_READ, 16'h0001, 8'h00);
    `CHK("ignored", 8'hA5, q)
    $display("deselect finished");
    frame(`INSTR_WRITE, `CMD_ADDR, 8'h80);
    `CHK("conv busy", 1'b0, done_out)
    wait_done;
    `CHK("conv time", 1'b1, cyc > `CONV_CYCLES - 64 && cyc <= `CONV_CYCLES)
    $display("conversion finished");
    rst_n_in <= 1'b0;
    repeat (8) @(posedge clk_in);
    #1 `CHK("pin reset", 1'b0, done_out)
    @(posedge clk_in);
    rst_n_in <= 1'b1;
    wait_done;
    `CHK("restart", 1'b1, cyc > `STARTUP_CYCLES - 4 && cyc < `STARTUP_CYCLES + 16)
    $display("pin reset finished");
    stop_test;
  end
endmodule
